/* bld_defs.svh */
/*
 Constants of the board local address decoder: quadrant codes, peripheral
 offsets, host port layout and command bits. Included by bld_pkg and the
 decoder files; holds definitions only.
*/
`ifndef BLD_DEFS_SVH
`define BLD_DEFS_SVH

// ----------------------------------------------------------------------
// Local memory quadrants (address bits 19:18)
// ----------------------------------------------------------------------
`define BLD_QUAD_LSB 18
`define BLD_QUAD_RAM 2'h0
`define BLD_QUAD_MMIO 2'h1
`define BLD_QUAD_WIN 2'h2
`define BLD_QUAD_ROM 2'h3
`define BLD_RAM_WAITS 2'h1
`define BLD_ROM_WAITS 2'h0
`define BLD_MMIO_WAITS 2'h0
`define BLD_WIN_LSB 16

// ----------------------------------------------------------------------
// Peripheral area offsets from peripheral_base
// ----------------------------------------------------------------------
`define BLD_OFS_ATTN 10'h000
`define BLD_OFS_ROM_LO 10'h080
`define BLD_OFS_ROM_HI 10'h0be
`define BLD_OFS_LEDLB 10'h100
`define BLD_OFS_UPADR 10'h102
`define BLD_OFS_IO_EN 10'h104
`define BLD_OFS_IO_DIS 10'h106
`define BLD_OFS_IRQ_DIS 10'h108
`define BLD_OFS_IRQ_EN 10'h10a
`define BLD_PERIPH_SPAN 10
`define BLD_ROM_WORDS 32

// ----------------------------------------------------------------------
// Host port block and command bits
// ----------------------------------------------------------------------
`define BLD_HOST_BASE_DEF 16'h00a8
`define BLD_HOST_WIDE_DEF 1'b0
`define BLD_PORT_CMD 2'h0
`define BLD_PORT_PTR_LO 2'h1
`define BLD_PORT_PTR_MID 2'h2
`define BLD_PORT_PTR_HI 2'h3
`define BLD_CMD_RESET_BIT 0
`define BLD_CMD_ATTN_BIT 1
`define BLD_CMD_IRQCLR_BIT 2

`endif

/* bld_pkg.sv */
/*
 Types of the board local address decoder. Assumes bld_defs.svh on the
 include path.
*/
`include "bld_defs.svh"

package bld_pkg;

    typedef enum logic [1:0] {
        BLD_REGION_RAM,
        BLD_REGION_MMIO,
        BLD_REGION_WIN,
        BLD_REGION_ROM
    } bld_region_type;

    // Local processor bus cycle
    typedef struct packed {
        logic        req;
        logic        wr;
        logic [19:0] addr;
        logic [7:0]  wdata;
    } bld_local_req_type;

    // Host I/O write cycle
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } bld_host_req_type;

    // Peripheral strobes, one-cycle pulses
    typedef struct packed {
        logic attn;
        logic led_loop_wr;
        logic upadr_wr;
        logic io_en;
        logic io_dis;
        logic irq_dis;
        logic irq_en;
    } bld_strobe_type;

endpackage

/* bld_host_ports.sv */
/*
 Host-side slave: four adjacent write-only byte ports on the host I/O
 space. Assumes host writes are one-cycle strobes synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

`include "bld_defs.svh"

module bld_host_ports
    import bld_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire bld_host_req_type host_req,
    input wire logic [15:0] host_base,
    input wire logic host_wide,
    output logic [23:0] config_pointer,
    output logic cmd_board_reset,
    output logic cmd_attention,
    output logic cmd_irq_clear
);

    logic [23:0] ptr_q;
    logic [23:0] ptr_d;
    logic hit;
    logic [1:0] port;

    // --------------------------------------------------------------
    // Port decode
    // --------------------------------------------------------------
    // Narrow decoding ignores the upper address byte entirely.
    always_comb
    begin
        port = host_req.addr[1:0];
        if (host_wide)
            hit = host_req.addr[15:2] == host_base[15:2];
        else
            hit = host_req.addr[7:2] == host_base[7:2];
        hit = hit && host_req.wr;
    end

    always_comb
    begin
        ptr_d = ptr_q;
        if (hit && port == `BLD_PORT_PTR_LO)
            ptr_d[7:0] = host_req.data;
        if (hit && port == `BLD_PORT_PTR_MID)
            ptr_d[15:8] = host_req.data;
        if (hit && port == `BLD_PORT_PTR_HI)
            ptr_d[23:16] = host_req.data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ptr_q <= 24'h000000;
        else
            ptr_q <= ptr_d;
    end

    assign config_pointer = ptr_q;

    // --------------------------------------------------------------
    // Command port, bits 7:3 ignored
    // --------------------------------------------------------------
    always_comb
    begin
        cmd_board_reset = hit && port == `BLD_PORT_CMD
                          && host_req.data[`BLD_CMD_RESET_BIT];
        cmd_attention = hit && port == `BLD_PORT_CMD
                        && host_req.data[`BLD_CMD_ATTN_BIT];
        cmd_irq_clear = hit && port == `BLD_PORT_CMD
                        && host_req.data[`BLD_CMD_IRQCLR_BIT];
    end

endmodule

`default_nettype wire

/* bld_decode.sv */
/*
 Board local address decoder: quadrant split, wait states, peripheral
 strobes and control latches, host port block. Assumes the local processor
 and host present synchronous requests on clk; host writes last one cycle. Jumper inputs
 host_base and host_wide are static; the station store is loaded through
 its load port before the first read.
*/
// Operation
// - Top quadrant selects EPROM with zero wait states.
// - Bottom quadrant selects RAM with exactly one wait state.
// - Three memory selects read back the host pointer bytes.
// - Station PROM read on even offsets 80h to BEh, one byte each.
// - Write at 100h latches LED-off bit 0 and loopback bit 1.
// - Write at 102h loads the bus upper address latch.
// - Write 104h enables bus I/O, 106h disables; data ignored.
// - Write 108h disables host interrupt, 10Ah enables it.
// - Board is slave at four adjacent write-only host byte ports.
// - Host base on any 4-byte boundary, 8- or 16-bit decoding.
// - Default host decode is 8-bit at base A8h.
// - Address bits 18 and 19 pick one of four quadrants.
// - Third quadrant is a bus window moved in 64K steps.
// - Command bits: 0 resets board, 1 attention, 2 clears irq.
// - Only local processor sets host irq; only host command bit 2 clears it.
`timescale 1ns/1ps
`default_nettype none

`include "bld_defs.svh"

module bld_decode
    import bld_pkg::*;
#(
    parameter logic [15:0] HOST_BASE = `BLD_HOST_BASE_DEF,
    parameter logic HOST_WIDE = `BLD_HOST_WIDE_DEF,
    parameter logic [19:0] MEM_SEL_BASE = 20'h40000,
    parameter logic [19:0] PERIPH_BASE = 20'h40400
)
(
    input wire logic clk,
    input wire logic rst,
    input wire bld_local_req_type local_req,
    output logic local_ready,
    output logic [7:0] local_rdata,
    output bld_region_type region,
    output logic ram_sel,
    output logic rom_sel,
    output logic win_sel,
    output logic [23:0] win_addr,
    input wire logic irq_set,
    input wire bld_host_req_type host_req,
    input wire logic [15:0] host_base,
    input wire logic host_wide,
    input wire logic station_we,
    input wire logic [4:0] station_waddr,
    input wire logic [7:0] station_wdata,
    output logic lan_attention,
    output logic led_off,
    output logic loopback,
    output logic bus_io_enabled,
    output logic host_irq,
    output logic board_reset_req
);

    logic [7:0] station_mem [0:`BLD_ROM_WORDS-1];
    logic [23:0] config_pointer;
    logic cmd_board_reset;
    logic cmd_attention;
    logic cmd_irq_clear;
    bld_strobe_type stb;
    logic periph_hit;
    logic mem_hit;
    logic [9:0] pofs;
    logic [19:0] prel;
    logic [19:0] mrel;
    logic [1:0] wait_need;

    logic [1:0] wait_q;
    logic [1:0] wait_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [1:0] ledlb_q;
    logic [1:0] ledlb_d;
    logic [7:0] upadr_q;
    logic [7:0] upadr_d;
    logic io_en_q;
    logic io_en_d;
    logic irq_en_q;
    logic irq_en_d;
    logic irq_q;
    logic irq_d;
    logic attn_q;
    logic attn_d;
    logic brst_q;
    logic brst_d;

    // ------------------------------------------------------------------
    // Host port block
    // ------------------------------------------------------------------
    bld_host_ports i_bld_host_ports (
        .clk(clk),
        .rst(rst),
        .host_req(host_req),
        .host_base(host_base),
        .host_wide(host_wide),
        .config_pointer(config_pointer),
        .cmd_board_reset(cmd_board_reset),
        .cmd_attention(cmd_attention),
        .cmd_irq_clear(cmd_irq_clear)
    );

    // ------------------------------------------------------------------
    // Station address store, loaded once at manufacture via the write port
    // ------------------------------------------------------------------
    // No reset: the contents must outlive a board reset, as a PROM would
    always_ff @(posedge clk)
    begin
        if (station_we)
            station_mem[station_waddr] <= station_wdata;
    end

    // ------------------------------------------------------------------
    // Quadrant decode
    // ------------------------------------------------------------------
    function automatic bld_region_type quad_of(input logic [19:0] a);
        quad_of = bld_region_type'(a[19:`BLD_QUAD_LSB]);
    endfunction

    function automatic logic quad_hit(input bld_local_req_type r,
                                      input bld_region_type q);
        quad_hit = r.req && quad_of(r.addr) == q;
    endfunction

    // Both spans are checked over 1K, the memory selects then cut to 4 bytes; a base near a quadrant edge loses the
    // part of its span that spills over, since the quadrant gate comes first
    localparam logic [19:0] SEL_SPAN = 20'h00001 << `BLD_PERIPH_SPAN;

    function automatic logic in_span(input logic [19:0] a,
                                     input logic [19:0] base);
        logic [19:0] d;
        d = a - base;
        in_span = a >= base && d < SEL_SPAN;
    endfunction

    always_comb
    begin
        region = quad_of(local_req.addr);
        ram_sel = quad_hit(local_req, BLD_REGION_RAM);
        rom_sel = quad_hit(local_req, BLD_REGION_ROM);
        win_sel = quad_hit(local_req, BLD_REGION_WIN);
        // Window bits 17:16 add to the latch so 64K steps overlap
        win_addr = {upadr_q, 16'h0000}
                   + {6'h00, local_req.addr[17:0]};
        // Selects outside the I/O quadrant are never honoured
        prel = local_req.addr - PERIPH_BASE;
        mrel = local_req.addr - MEM_SEL_BASE;
        pofs = prel[9:0];
        periph_hit = quad_hit(local_req, BLD_REGION_MMIO)
                     && in_span(local_req.addr, PERIPH_BASE);
        mem_hit = quad_hit(local_req, BLD_REGION_MMIO)
                  && in_span(local_req.addr, MEM_SEL_BASE)
                  && mrel[9:2] == 8'h00;
        unique case (region)
            BLD_REGION_RAM: wait_need = `BLD_RAM_WAITS;
            BLD_REGION_ROM: wait_need = `BLD_ROM_WAITS;
            default: wait_need = `BLD_MMIO_WAITS;
        endcase
    end

    // ------------------------------------------------------------------
    // Peripheral strobes
    // ------------------------------------------------------------------
    always_comb
    begin
        stb = '0;
        if (periph_hit && local_req.wr)
        begin
            stb.attn = pofs == `BLD_OFS_ATTN;
            stb.led_loop_wr = pofs == `BLD_OFS_LEDLB;
            stb.upadr_wr = pofs == `BLD_OFS_UPADR;
            stb.io_en = pofs == `BLD_OFS_IO_EN;
            stb.io_dis = pofs == `BLD_OFS_IO_DIS;
            stb.irq_dis = pofs == `BLD_OFS_IRQ_DIS;
            stb.irq_en = pofs == `BLD_OFS_IRQ_EN;
        end
        // Channel attention answers reads too: any access strobes it
        if (periph_hit && !local_req.wr && pofs == `BLD_OFS_ATTN)
            stb.attn = 1'b1;
    end

    // ------------------------------------------------------------------
    // Wait states and read data
    // ------------------------------------------------------------------
    // The request is held by the processor until local_ready.
    // The count clears whenever req is low, so a dropped access starts anew.
    always_comb
    begin
        wait_d = 2'h0;
        if (local_req.req && wait_q != wait_need)
            wait_d = wait_q + 2'h1;
        local_ready = local_req.req && wait_q == wait_need;
        // Write-only offsets, the window and EPROM all read back as zero
        rdata_d = 8'h00;
        if (mem_hit)
        begin
            unique case (mrel[1:0])
                2'h0: rdata_d = config_pointer[7:0];
                2'h1: rdata_d = config_pointer[15:8];
                2'h2: rdata_d = config_pointer[23:16];
                default: rdata_d = 8'h00;
            endcase
        end
        if (periph_hit && !pofs[0] && pofs >= `BLD_OFS_ROM_LO
            && pofs <= `BLD_OFS_ROM_HI)
            rdata_d = station_mem[pofs[5:1]];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_q <= 2'h0;
            rdata_q <= 8'h00;
        end
        else
        begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // Data registered; valid in the cycle after the select is seen
    assign local_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Control latches
    // ------------------------------------------------------------------
    always_comb
    begin
        ledlb_d = ledlb_q;
        upadr_d = upadr_q;
        io_en_d = io_en_q;
        irq_en_d = irq_en_q;
        irq_d = irq_q;
        if (stb.led_loop_wr && local_ready)
            ledlb_d = local_req.wdata[1:0];
        if (stb.upadr_wr && local_ready)
            upadr_d = local_req.wdata;
        if (stb.io_en && local_ready)
            io_en_d = 1'b1;
        if (stb.io_dis && local_ready)
            io_en_d = 1'b0;
        if (stb.irq_dis && local_ready)
            irq_en_d = 1'b0;
        if (stb.irq_en && local_ready)
            irq_en_d = 1'b1;
        // Set beats a host clear arriving in the same cycle
        if (cmd_irq_clear)
            irq_d = 1'b0;
        if (irq_set)
            irq_d = 1'b1;
        // One-cycle pulses: each request strobe is itself one cycle long
        attn_d = (stb.attn && local_ready) || cmd_attention;
        brst_d = cmd_board_reset;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ledlb_q <= 2'h0;
            upadr_q <= 8'h00;
            io_en_q <= 1'b0;
            irq_en_q <= 1'b0;
            irq_q <= 1'b0;
            attn_q <= 1'b0;
            brst_q <= 1'b0;
        end
        else
        begin
            ledlb_q <= ledlb_d;
            upadr_q <= upadr_d;
            io_en_q <= io_en_d;
            irq_en_q <= irq_en_d;
            irq_q <= irq_d;
            attn_q <= attn_d;
            brst_q <= brst_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Disable only gates the output; the pending request survives it
    assign host_irq = irq_q && irq_en_q;
    assign led_off = ledlb_q[0];
    assign loopback = ledlb_q[1];
    assign bus_io_enabled = io_en_q;
    assign lan_attention = attn_q;
    assign board_reset_req = brst_q;

endmodule

`default_nettype wire

/* bld_decode_properties.sv */
/*
 Checker for bld_decode: timing of local answers, quadrant split, strobes
 and host command port. Assumes it is bound to bld_decode, one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module bld_decode_properties
    import bld_pkg::*;
#(
    parameter logic [19:0] PERIPH_BASE = 20'h40400
)
(
    input wire logic clk,
    input wire logic rst,
    input wire bld_local_req_type local_req,
    input wire logic local_ready,
    input wire bld_region_type region,
    input wire logic ram_sel,
    input wire logic rom_sel,
    input wire logic win_sel,
    input wire logic irq_set,
    input wire bld_host_req_type host_req,
    input wire logic [15:0] host_base,
    input wire logic host_wide,
    input wire logic lan_attention,
    input wire logic led_off,
    input wire logic loopback,
    input wire logic bus_io_enabled,
    input wire logic host_irq,
    input wire logic board_reset_req
);
    logic cmd_hit;
    logic loc_wr;
    logic [19:0] ofs;

    // ----------
    // Helpers
    // ----------
    assign cmd_hit = host_req.wr && host_req.addr[1:0] == 2'h0 &&
        (host_wide ? host_req.addr[15:2] == host_base[15:2]
                   : host_req.addr[7:2] == host_base[7:2]);
    assign loc_wr = local_req.req && local_req.wr && local_ready;
    assign ofs = local_req.addr - PERIPH_BASE;

    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    a_rom_no_wait: assert property (local_req.req &&
        local_req.addr[19:18] == 2'h3 |-> local_ready)
        else $error("rom access stalled");
    a_ram_one_wait: assert property ($rose(local_req.req) &&
        local_req.addr[19:18] == 2'h0 |-> !local_ready ##1 local_ready)
        else $error("ram wait state wrong");
    a_quad_split: assert property (
        region == bld_region_type'(local_req.addr[19:18]))
        else $error("region does not follow address");
    a_attn_pulse: assert property ((local_req.req &&
        local_ready && ofs == 20'h0) || (cmd_hit && host_req.data[1])
        |=> lan_attention) else $error("attention missing");
    a_led_latch: assert property (loc_wr && ofs == 20'h100 |=>
        led_off == $past(local_req.wdata[0]) &&
        loopback == $past(local_req.wdata[1]))
        else $error("led or loopback not latched");
    a_io_on: assert property (loc_wr && ofs == 20'h104 |=>
        bus_io_enabled) else $error("bus io not enabled");
    a_io_off: assert property (loc_wr && ofs == 20'h106 |=>
        !bus_io_enabled) else $error("bus io not disabled");
    a_irq_mask: assert property (loc_wr && ofs == 20'h108 |->
        ##[1:2] !host_irq) else $error("host irq not masked");
    a_host_reset: assert property (cmd_hit &&
        host_req.data[0] |=> board_reset_req)
        else $error("board reset missing");
    a_host_clear: assert property (cmd_hit && host_req.data[2] &&
        !irq_set |-> ##[1:2] !host_irq) else $error("host irq not cleared");
    a_sel_decode: assert property (
        ram_sel == (local_req.req && local_req.addr[19:18] == 2'h0) &&
        rom_sel == (local_req.req && local_req.addr[19:18] == 2'h3) &&
        win_sel == (local_req.req && local_req.addr[19:18] == 2'h2))
        else $error("quadrant select wrong");
endmodule

bind bld_decode bld_decode_properties #(.PERIPH_BASE(PERIPH_BASE))
    i_bld_decode_properties (.clk(clk), .rst(rst), .local_req(local_req),
    .local_ready(local_ready), .region(region), .irq_set(irq_set),
    .ram_sel(ram_sel), .rom_sel(rom_sel), .win_sel(win_sel),
    .host_req(host_req), .host_base(host_base), .host_wide(host_wide),
    .lan_attention(lan_attention), .led_off(led_off),
    .loopback(loopback), .bus_io_enabled(bus_io_enabled),
    .host_irq(host_irq), .board_reset_req(board_reset_req));

`default_nettype wire

/* bld_bus_model.sv */
/*
 Model of the local processor and the host bus master. Assumes one clock
 shared with the decoder; the testbench calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none

module bld_bus_model
    import bld_pkg::*;
(
    input wire logic clk,
    input wire logic local_ready,
    input wire logic [7:0] local_rdata,
    input wire logic [23:0] win_addr,
    output bld_local_req_type local_req,
    output bld_host_req_type host_req
);
    int waits;
    logic [23:0] last_win;

    initial
    begin
        local_req = '0;
        host_req = '0;
    end

    // Released lines show the inverse so a stale value never looks valid
    task loc(input logic wr, input logic [19:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        n = 0;
        q = 8'h00;
        @(posedge clk);
        local_req <= '{1'b1, wr, a, d};
        @(posedge clk);
        while (local_ready !== 1'b1 && n < 8)
        begin
            n++;
            @(posedge clk);
        end
        waits = n;
        last_win = win_addr;
        local_req <= '{1'b0, 1'b0, ~a, ~d};
        if (!wr)
        begin
            @(posedge clk);
            q = local_rdata;
        end
    endtask

    // Host only writes; one-cycle strobe
    task hw(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        host_req <= '{1'b1, a, d};
        @(posedge clk);
        host_req <= '{1'b0, ~a, ~d};
    endtask
endmodule

`default_nettype wire

/* tb_bld_decode.sv */
/*
 Self-checking testbench of bld_decode. Assumes the checker is bound by
 its own file and the bus model stands in for processor and host.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_bld_decode
    import bld_pkg::*;
;
    localparam logic [19:0] PB = 20'h40400;
    localparam logic [19:0] MB = 20'h40000;
    logic clk, rst, irq_set, host_wide, station_we;
    logic local_ready, lan_attention, led_off, loopback;
    logic bus_io_enabled, host_irq, board_reset_req;
    logic [15:0] host_base;
    logic [4:0] station_waddr;
    logic [7:0] station_wdata, local_rdata, rd;
    logic [23:0] win_addr;
    bld_local_req_type local_req;
    bld_host_req_type host_req;
    int fails, total_checks;

    bld_decode i_bld_decode (.clk(clk), .rst(rst), .local_req(local_req),
        .local_ready(local_ready), .local_rdata(local_rdata), .region(),
        .ram_sel(), .rom_sel(), .win_sel(), .win_addr(win_addr),
        .irq_set(irq_set), .host_req(host_req), .host_base(host_base),
        .host_wide(host_wide), .station_we(station_we),
        .station_waddr(station_waddr), .station_wdata(station_wdata),
        .lan_attention(lan_attention), .led_off(led_off),
        .loopback(loopback), .bus_io_enabled(bus_io_enabled),
        .host_irq(host_irq), .board_reset_req(board_reset_req));

    bld_bus_model i_bld_bus_model (.clk(clk), .local_ready(local_ready),
        .local_rdata(local_rdata), .win_addr(win_addr),
        .local_req(local_req), .host_req(host_req));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task results;
        if (fails == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task wrl(input logic [19:0] o, input logic [7:0] d);
        i_bld_bus_model.loc(1'b1, PB + o, d, rd);
        repeat (2) @(posedge clk);
    endtask

    // Pulse outputs are looked at in the one cycle they stand
    task hpulse(input logic [15:0] a, input logic [7:0] d,
        input logic ea, input logic er);
        i_bld_bus_model.hw(a, d);
        @(posedge clk);
        chk(lan_attention, ea);
        chk(board_reset_req, er);
        @(posedge clk);
        chk(lan_attention, 1'b0);
    endtask

    initial
    begin
        #50us;
        fails++;
        results;
    end

    // ----------
    // Main sequence
    // ----------
    initial
    begin
        rst = 1'b1;
        irq_set = 1'b0;
        host_wide = 1'b0;
        host_base = 16'h00a8;
        station_we = 1'b0;
        station_waddr = 5'h00;
        station_wdata = 8'h00;
        fails = 0;
        total_checks = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(bus_io_enabled, 1'b0);
        hpulse(16'h00a8, 8'hfa, 1'b1, 1'b0);
        hpulse(16'h00ac, 8'h03, 1'b0, 1'b0);
        hpulse(16'h00a9, 8'h02, 1'b0, 1'b0);
        hpulse(16'h00a8, 8'h01, 1'b0, 1'b1);
        host_wide <= 1'b1;
        host_base <= 16'h1234;
        hpulse(16'h1234, 8'h02, 1'b1, 1'b0);
        hpulse(16'h0034, 8'h02, 1'b0, 1'b0);
        host_wide <= 1'b0;
        host_base <= 16'h00a8;
        for (int n = 0; n < 3; n++)
            i_bld_bus_model.hw(16'h00a9 + 16'(n),
                8'h11 * 8'(n + 1));
        for (int n = 0; n < 3; n++)
        begin
            i_bld_bus_model.loc(1'b0, MB + 20'(n), 8'h00, rd);
            chk(rd, 8'h11 * 8'(n + 1));
        end
        for (int n = 0; n < 32; n++)
        begin
            station_we <= 1'b1;
            station_waddr <= 5'(n);
            station_wdata <= 8'h50 + 8'(n);
            @(posedge clk);
        end
        station_we <= 1'b0;
        for (int n = 0; n < 32; n++)
        begin
            i_bld_bus_model.loc(1'b0, PB + 20'h80 + 20'(2 * n),
                8'h00, rd);
            chk(rd, 8'h50 + 8'(n));
        end
        i_bld_bus_model.loc(1'b1, PB, 8'h00, rd);
        @(posedge clk);
        chk(lan_attention, 1'b1);
        // A read at the attention offset strobes too and returns zero
        i_bld_bus_model.loc(1'b0, PB, 8'h00, rd);
        chk(lan_attention, 1'b1);
        chk(rd, 8'h00);
        wrl(20'h100, 8'h03);
        chk({loopback, led_off}, 2'h3);
        wrl(20'h100, 8'h02);
        chk({loopback, led_off}, 2'h2);
        wrl(20'h104, 8'h00);
        chk(bus_io_enabled, 1'b1);
        wrl(20'h106, 8'hff);
        chk(bus_io_enabled, 1'b0);
        wrl(20'h102, 8'h12);
        i_bld_bus_model.loc(1'b0, 20'h80005, 8'h00, rd);
        chk(i_bld_bus_model.last_win, 24'h120005);
        chk(24'(i_bld_bus_model.waits), 24'h0);
        i_bld_bus_model.loc(1'b0, 20'hc0010, 8'h00, rd);
        chk(24'(i_bld_bus_model.waits), 24'h0);
        i_bld_bus_model.loc(1'b0, 20'h3fff0, 8'h00, rd);
        chk(24'(i_bld_bus_model.waits), 24'h1);
        wrl(20'h10a, 8'h00);
        irq_set <= 1'b1;
        @(posedge clk);
        irq_set <= 1'b0;
        repeat (2) @(posedge clk);
        chk(host_irq, 1'b1);
        wrl(20'h108, 8'h00);
        chk(host_irq, 1'b0);
        wrl(20'h10a, 8'h00);
        chk(host_irq, 1'b1);
        i_bld_bus_model.hw(16'h00a8, 8'h04);
        repeat (2) @(posedge clk);
        chk(host_irq, 1'b0);
        results;
    end
endmodule

`default_nettype wire
